// *** verilog/tsx_pkg.sv ***
// Shared constants and types for the eight-channel register transceiver
package tsx_pkg;

	// Data path width of each bus
	localparam int TSX_WIDTH = 8;

	// Register byte offsets on the AHB-Lite port
	localparam logic [7:0] TSX_CTRL_OFS = 8'h00;
	localparam logic [7:0] TSX_STORE_OFS = 8'h04;
	localparam logic [7:0] TSX_LIVE_OFS = 8'h08;

	// Control register field positions
	localparam int TSX_AB_OE_POS = 0;
	localparam int TSX_BA_OE_N_POS = 1;
	localparam int TSX_AB_SEL_POS = 2;
	localparam int TSX_BA_SEL_POS = 3;

	// Store and live register field positions
	localparam int TSX_A_FIELD_POS = 0;
	localparam int TSX_B_FIELD_POS = 8;

	// Reset values: both driver sets off, real-time data selected
	localparam logic TSX_AB_OE_RST = 1'b0;
	localparam logic TSX_BA_OE_N_RST = 1'b1;
	localparam logic TSX_AB_SEL_RST = 1'b0;
	localparam logic TSX_BA_SEL_RST = 1'b0;
	localparam logic [7:0] TSX_DATA_RST = 8'h00;

	// AHB transfer type that opens a single transfer
	localparam logic [1:0] TSX_HTRANS_NONSEQ = 2'h2;

	// Control bits as one carrier
	typedef struct packed {
		logic b_to_a_select;
		logic a_to_b_select;
		logic b_to_a_output_enable_n;
		logic a_to_b_output_enable;
	} tsx_ctrl_t;

	// One driven bus: values and per-line enables
	typedef struct packed {
		logic [TSX_WIDTH-1:0] value;
		logic [TSX_WIDTH-1:0] oe;
	} tsx_drive_t;

endpackage

// *** verilog/tsx_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
// Rising-edge detector for a capture clock pin sampled on clk
module tsx_edge
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic level,
	output logic rise
);
	import tsx_pkg::*;

	// Previous sample of the pin
	logic prev_reg;

	// Starts high so a pin already high at release gives no edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			prev_reg <= 1'b1;
		else
			prev_reg <= level;
	end

	// One-cycle enable on each low-to-high transition
	assign rise = level & ~prev_reg;

endmodule
`default_nettype wire

// *** verilog/tsx_lane.sv ***
`timescale 1ns/1ps
`default_nettype none
// One direction: capture register plus registered output selector
module tsx_lane
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic capture,
	input wire logic [7:0] cap_data,
	input wire logic [7:0] live_data,
	input wire logic sel_stored,
	input wire logic drive_en,
	output logic [7:0] stored,
	output tsx_pkg::tsx_drive_t drive
);
	import tsx_pkg::*;

	// Next value of the driven lines
	logic [TSX_WIDTH-1:0] value_next;
	logic [TSX_WIDTH-1:0] oe_next;

	// Capture register loads on every edge, whatever select or enable say
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			stored <= TSX_DATA_RST;
		else if (capture)
			stored <= cap_data;
	end

	// Low select passes live data, high select passes stored data
	assign value_next = sel_stored ? stored : live_data;

	// Each line's enable follows the direction enable
	genvar i;
	generate
		for (i = 0; i < TSX_WIDTH; i++)
		begin : g_oe
			assign oe_next[i] = drive_en;
		end
	endgenerate

	// Registered output changes once per cycle, so a select change cannot glitch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drive.value <= TSX_DATA_RST;
			drive.oe <= '0; // Undriven from reset
		end
		else
		begin
			drive.value <= value_next;
			drive.oe <= oe_next;
		end
	end

endmodule
`default_nettype wire

// *** verilog/tsx_top.sv ***
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Capture edges load both registers, ignoring controls
// - Bus pins sampled even while driven
// - Select low passes live, high stored
// - Select changes never glitch the driven bus
// - Independent enables; B active high, A low
// - B enabled, select low: live A onto B
// - B enabled, select high: A register onto B
// - A enabled, select low: live B onto A
// - A enabled, select high: B register onto A
// - Both enabled, both stored: cross-drive registers
// - Only B driven: both registers take A
// - Only A driven: both registers take B
// - Both live and enabled: ports hold levels; here equal levels hold and differing levels swap each cycle
module tsx_top
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic a_capture_clock,
	input wire logic b_capture_clock,
	input wire logic [7:0] a_bus_in,
	output logic [7:0] a_bus_out,
	output logic [7:0] a_bus_oe,
	input wire logic [7:0] b_bus_in,
	output logic [7:0] b_bus_out,
	output logic [7:0] b_bus_oe
);
	import tsx_pkg::*;

	// Control register and its next value
	tsx_ctrl_t ctrl_reg;
	tsx_ctrl_t ctrl_next;

	// Data phase bookkeeping for a pending write
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;

	// Registered bus answer
	logic [31:0] hrdata_next;

	// Address phase decode
	wire addr_take;
	wire rd_take;
	wire wr_take;
	wire [7:0] addr_ofs;
	wire addr_hit_ctrl;
	wire addr_hit_store;
	wire addr_hit_live;
	wire wr_ctrl;

	// Capture enables from the pin edges
	wire a_rise;
	wire b_rise;

	// Direction enables decoded from the control register
	wire b_drive;
	wire a_drive;

	// Capture sources for each register
	wire [7:0] a_cap_src;
	wire [7:0] b_cap_src;

	// Register contents
	wire [7:0] a_stored;
	wire [7:0] b_stored;

	// Driven lines of each port
	tsx_drive_t b_drive_lines;
	tsx_drive_t a_drive_lines;

	// Readable words
	wire [31:0] ctrl_word;
	wire [31:0] store_word;
	wire [31:0] live_word;

	// Request accepted when selected, ready and a single transfer opens
	assign addr_take = hsel & hready & (htrans == TSX_HTRANS_NONSEQ);
	assign rd_take = addr_take & ~hwrite;
	assign wr_take = addr_take & hwrite;

	// The low byte of the address selects a register; bits 31:8 must be zero
	assign addr_ofs = haddr[7:0];
	assign addr_hit_ctrl = (haddr[31:8] == 24'h000000) & (addr_ofs == TSX_CTRL_OFS);
	assign addr_hit_store = (haddr[31:8] == 24'h000000) & (addr_ofs == TSX_STORE_OFS);
	assign addr_hit_live = (haddr[31:8] == 24'h000000) & (addr_ofs == TSX_LIVE_OFS);

	// Write to control lands in its data phase
	assign wr_ctrl = wr_pend_reg & (wr_addr_reg == TSX_CTRL_OFS);

	// Control word as software sees it
	assign ctrl_word = {28'h0000000, ctrl_reg};

	// Both register contents side by side
	assign store_word = {16'h0000, b_stored, a_stored};

	// Present levels on both buses
	assign live_word = {16'h0000, b_bus_in, a_bus_in};

	// Read data chosen during the address phase, unmapped reads give zero
	always_comb
	begin
		hrdata_next = 32'h00000000;
		if (rd_take)
		begin
			// Pick the word of the addressed register
			if (addr_hit_ctrl)
				hrdata_next = ctrl_word;
			else if (addr_hit_store)
				hrdata_next = store_word;
			else if (addr_hit_live)
				hrdata_next = live_word;
			else
				hrdata_next = 32'h00000000;
		end
	end

	// Control register takes the data phase word; other bits unchanged
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
		begin
			// Only the four low bits are writable
			ctrl_next.a_to_b_output_enable = hwdata[TSX_AB_OE_POS];
			ctrl_next.b_to_a_output_enable_n = hwdata[TSX_BA_OE_N_POS];
			ctrl_next.a_to_b_select = hwdata[TSX_AB_SEL_POS];
			ctrl_next.b_to_a_select = hwdata[TSX_BA_SEL_POS];
		end
	end

	// Remember a write across its address phase
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_reg <= wr_take & addr_hit_ctrl;
			wr_addr_reg <= addr_ofs;
		end
	end

	// Control register with both drivers off after reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_reg.a_to_b_output_enable <= TSX_AB_OE_RST;
			ctrl_reg.b_to_a_output_enable_n <= TSX_BA_OE_N_RST;
			ctrl_reg.a_to_b_select <= TSX_AB_SEL_RST;
			ctrl_reg.b_to_a_select <= TSX_BA_SEL_RST;
		end
		else
			ctrl_reg <= ctrl_next;
	end

	// Bus answer: zero wait, always OKAY, data held until next read
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_take)
				hrdata <= hrdata_next;
		end
	end

	// Edge of the A capture pin
	tsx_edge u_a_edge
	(
		.clk(clk),
		.rst_b(rst_b),
		.level(a_capture_clock),
		.rise(a_rise)
	);

	// Edge of the B capture pin
	tsx_edge u_b_edge
	(
		.clk(clk),
		.rst_b(rst_b),
		.level(b_capture_clock),
		.rise(b_rise)
	);

	// B drivers on while enable high, A drivers on while enable_n low
	assign b_drive = ctrl_reg.a_to_b_output_enable;
	assign a_drive = ~ctrl_reg.b_to_a_output_enable_n;

	// A register takes the A bus; if A carries live B, take B directly
	assign a_cap_src = (a_drive & ~ctrl_reg.b_to_a_select) ? b_bus_in : a_bus_in;

	// B register takes the B bus; if B carries live A, take A directly
	assign b_cap_src = (b_drive & ~ctrl_reg.a_to_b_select) ? a_bus_in : b_bus_in;

	// A-to-B lane: live A or A register onto B
	// With stored select, simultaneous edges give the old value on B
	tsx_lane u_ab
	(
		.clk(clk),
		.rst_b(rst_b),
		.capture(a_rise),
		.cap_data(a_cap_src),
		.live_data(a_bus_in),
		.sel_stored(ctrl_reg.a_to_b_select),
		.drive_en(b_drive),
		.stored(a_stored),
		.drive(b_drive_lines)
	);

	// B-to-A lane: live B or B register onto A
	// Both lanes run apart, so both may cross-drive together
	tsx_lane u_ba
	(
		.clk(clk),
		.rst_b(rst_b),
		.capture(b_rise),
		.cap_data(b_cap_src),
		.live_data(b_bus_in),
		.sel_stored(ctrl_reg.b_to_a_select),
		.drive_en(a_drive),
		.stored(b_stored),
		.drive(a_drive_lines)
	);

	// Port pins straight from lane flops; live loops swap A and B levels each cycle, so only equal levels hold
	assign b_bus_out = b_drive_lines.value;
	assign b_bus_oe = b_drive_lines.oe;
	assign a_bus_out = a_drive_lines.value;
	assign a_bus_oe = a_drive_lines.oe;

endmodule
`default_nettype wire

// *** bench/tsx_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Other drivers on both buses; a released line toggles each cycle
module tsx_partner
(
	input wire logic clk,
	input wire logic [7:0] a_out,
	input wire logic [7:0] a_oe,
	input wire logic [7:0] b_out,
	input wire logic [7:0] b_oe,
	input wire logic a_en,
	input wire logic b_en,
	input wire logic [7:0] a_val,
	input wire logic [7:0] b_val,
	output logic [7:0] a_lvl,
	output logic [7:0] b_lvl
);
	logic [7:0] a_last = 8'h00; // Previous A level
	logic [7:0] b_last = 8'h00; // Previous B level
	// Device wins, then this driver, else inverse of last level
	assign a_lvl = (a_oe & a_out) | (~a_oe & (a_en ? a_val : ~a_last));
	assign b_lvl = (b_oe & b_out) | (~b_oe & (b_en ? b_val : ~b_last));
	// Remember levels for the floating pattern
	always @(posedge clk)
	begin
		a_last <= a_lvl;
		b_last <= b_lvl;
	end
endmodule
`default_nettype wire

// *** bench/tsx_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port checks; control bits are mirrored from bus writes
module tsx_top_assertions
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic [7:0] a_bus_in,
	input wire logic [7:0] a_bus_out,
	input wire logic [7:0] a_bus_oe,
	input wire logic [7:0] b_bus_in,
	input wire logic [7:0] b_bus_out,
	input wire logic [7:0] b_bus_oe
);
	import tsx_pkg::*;
	wire req = hsel && hready && htrans == TSX_HTRANS_NONSEQ; // Accepted address phase
	logic wr_q; // Control write in data phase
	logic [3:0] c_q; // Shadow control bits
	// Mirror control writes at the end of their data phase
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_q <= 1'b0;
			c_q <= 4'h2;
		end
		else
		begin
			wr_q <= req && hwrite && haddr == 32'h0;
			if (wr_q)
				c_q <= hwdata[3:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Read of the live bus levels
	sequence live_rd;
		req && !hwrite && haddr == 32'h8;
	endsequence
	a_ready_ok: assert property (hreadyout && !hresp) else $error("bus wait or error");
	a_oe_whole: assert property ({a_bus_oe, b_bus_oe} inside {16'h0, 16'hff, 16'hff00, 16'hffff})
		else $error("enables split");
	a_reset_off: assert property ($rose(rst_b) |-> {a_bus_oe, b_bus_oe} == 16'h0)
		else $error("driving after reset");
	a_ab_live: assert property ($past(c_q[0] && !c_q[2]) |->
		b_bus_oe == 8'hff && b_bus_out == $past(a_bus_in)) else $error("B not live");
	a_ba_live: assert property ($past(!c_q[1] && !c_q[3]) |->
		a_bus_oe == 8'hff && a_bus_out == $past(b_bus_in)) else $error("A not live");
	a_ab_off: assert property ($past(!c_q[0]) |-> b_bus_oe == 8'h00)
		else $error("B driven");
	a_ba_off: assert property ($past(c_q[1]) |-> a_bus_oe == 8'h00)
		else $error("A driven");
	a_rd_hold: assert property (!$past(req && !hwrite) |-> $stable(hrdata))
		else $error("read data moved");
	a_live_rd: assert property (live_rd |=> hrdata[15:0] == {$past(b_bus_in), $past(a_bus_in)})
		else $error("live read wrong");
endmodule
bind tsx_top tsx_top_assertions u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .a_bus_in(a_bus_in), .a_bus_out(a_bus_out),
	.a_bus_oe(a_bus_oe), .b_bus_in(b_bus_in), .b_bus_out(b_bus_out), .b_bus_oe(b_bus_oe));
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Random bench: modes, captures, select switch, hold loop
module tb_top;
	import tsx_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
	logic cka = 1'b0, ckb = 1'b0, pa = 1'b0, pb = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0] ai, ao, aoe, bi, bo, boe, va, vb, na, nb, pva = 8'h00, pvb = 8'h00;
	logic [15:0] lv;
	logic [3:0] md [6] = '{4'h2, 4'h3, 4'h7, 4'h0, 4'h8, 4'hd};
	int errors = 0, cmp_count = 0, seed = 32'h8952;
	always #12.5 clk = ~clk;
	tsx_top DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
		.hrdata(hrdata), .hresp(hresp), .a_capture_clock(cka), .b_capture_clock(ckb),
		.a_bus_in(ai), .a_bus_out(ao), .a_bus_oe(aoe), .b_bus_in(bi), .b_bus_out(bo),
		.b_bus_oe(boe));
	tsx_partner u_far (.clk(clk), .a_out(ao), .a_oe(aoe), .b_out(bo), .b_oe(boe), .a_en(pa),
		.b_en(pb), .a_val(pva), .b_val(pvb), .a_lvl(ai), .b_lvl(bi));
	// Compare and count
	task chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One single AHB transfer, read data into rd
	task ahb(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= TSX_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	// Capture pulse after the buses settle
	task cap(input logic [1:0] p);
		repeat (2) @(posedge clk);
		{ckb, cka} <= p;
		@(posedge clk);
		{ckb, cka} <= 2'b00;
		repeat (3) @(posedge clk);
	endtask
	// Expected {B,A} levels; partner holds na/nb on undriven buses
	function automatic logic [15:0] lvl(input logic [3:0] c, input logic [7:0] sa, sb);
		logic [7:0] a, b;
		a = c[1] ? na : sb;
		b = c[0] ? (c[2] ? sa : a) : nb;
		if (!c[1] && !c[3])
			a = b;
		return {b, a};
	endfunction
	task finish_test;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#100000;
		errors++;
		finish_test;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk("oe", {16'h0, aoe, boe}, 32'h0);
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctrl", rd, 32'h2);
		ahb(1'b1, 32'h4, 32'hffff);
		ahb(1'b0, 32'h4, 32'h0);
		chk("ro", rd, 32'h0);
		ahb(1'b0, 32'h100, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("registers done");
		foreach (md[i])
		begin
			{va, vb, na, nb} = $random(seed);
			pva <= va;
			pvb <= vb;
			pa <= 1'b1;
			pb <= 1'b1;
			ahb(1'b1, 32'h0, 32'h2);
			cap(2'b11);
			ahb(1'b0, 32'h4, 32'h0);
			chk("store", rd, {16'h0, vb, va});
			ahb(1'b0, 32'h8, 32'h0);
			chk("live", rd, {16'h0, vb, va});
			pva <= na;
			pvb <= nb;
			pa <= md[i][1];
			pb <= !md[i][0];
			ahb(1'b1, 32'h0, {28'h0, md[i]});
			repeat (3) @(posedge clk);
			chk("levels", {bi, ai}, lvl(md[i], va, vb));
			cap(2'b01);
			lv = lvl(md[i], va, vb);
			va = lv[7:0];
			cap(2'b10);
			lv = lvl(md[i], va, vb);
			vb = lv[15:8];
			ahb(1'b0, 32'h4, 32'h0);
			chk("stored", rd, {16'h0, vb, va});
			$display("mode %h done", md[i]);
		end
		// B from live to stored: only old or new value may show
		pva <= na;
		pa <= 1'b1;
		ahb(1'b1, 32'h0, 32'h3);
		repeat (3) @(posedge clk);
		ahb(1'b1, 32'h0, 32'h7);
		repeat (4)
		begin
			@(posedge clk);
			chk("switch", {31'h0, bo == na || bo == va}, 32'h1);
		end
		chk("stored out", bo, va);
		// Both live and enabled, then release: levels must stay
		pvb <= na;
		pb <= 1'b1;
		ahb(1'b1, 32'h0, 32'h2);
		ahb(1'b1, 32'h0, 32'h1);
		repeat (2) @(posedge clk);
		pa <= 1'b0;
		pb <= 1'b0;
		repeat (4) @(posedge clk);
		chk("hold", {bi, ai}, {na, na});
		$display("loop done");
		finish_test;
	end
endmodule
`default_nettype wire
